// >>> ext_mem_bus.v
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.vh"

module ext_mem_bus
(
    input  wire                 SYS_CLK,
    input  wire                 RST_B,
    input  wire                 RESET_PIN,
    input  wire                 EXT_ACCESS_SEL_B,
    input  wire                 REQ,
    input  wire [1:0]           REQ_KIND,
    input  wire [`ADDR_W-1:0]   REQ_ADDR,
    input  wire [7:0]           REQ_WDATA,
    output reg                  BUSY,
    output reg                  ACK,
    output reg  [7:0]           RDATA,
    input  wire [7:0]           LOW_ADDR_DATA_PORT_IN,
    output reg  [7:0]           LOW_ADDR_DATA_PORT_OUT,
    output reg  [7:0]           LOW_ADDR_DATA_PORT_OE,
    output reg  [7:0]           HIGH_ADDRESS_PORT,
    output reg                  ADDR_LATCH_STB,
    output reg                  PROGRAM_FETCH_STB_B,
    output reg                  DATA_WR_STB_B,
    output reg                  DATA_RD_STB_B,
    input  wire                 ROM_PROG_WE,
    input  wire [`ROM_AW-1:0]   ROM_PROG_ADDR,
    input  wire [7:0]           ROM_PROG_DATA
);

    // True for accesses to program space, which use the fetch strobe
    function is_code;
        input [1:0] kind;
        begin
            is_code = (kind == `KIND_FETCH) || (kind == `KIND_CODE_LOAD);
        end
    endfunction

    reg  [1:0]          rst_sync_ff;
    reg  [1:0]          sel_sync_ff;
    reg  [7:0]          din_meta_ff;
    reg  [7:0]          din_sync_ff;
    reg  [4:0]          rst_cnt_ff;
    reg                 bus_rst_ff;
    reg  [2:0]          state_ff;
    reg  [2:0]          cnt_ff;
    reg  [1:0]          kind_ff;
    reg  [7:0]          wdata_ff;
    reg  [2:0]          nxt_state;
    reg  [2:0]          nxt_cnt;
    reg  [1:0]          nxt_kind;
    reg  [7:0]          nxt_wdata;
    reg                 nxt_busy;
    reg                 nxt_ack;
    reg  [7:0]          nxt_rdata;
    reg  [7:0]          nxt_port_out;
    reg  [7:0]          nxt_port_oe;
    reg  [7:0]          nxt_high;
    reg                 nxt_ale;
    reg                 nxt_fetch_b;
    reg                 nxt_wr_b;
    reg                 nxt_rd_b;
    wire [7:0]          rom_q;
    wire                take;
    wire                go_internal;

    // Pins come from outside the clock domain: two flops before any use
    always @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rst_sync_ff <= 2'h0;
            sel_sync_ff <= 2'h3;
            din_meta_ff <= 8'h00;
            din_sync_ff <= 8'h00;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], RESET_PIN};
            sel_sync_ff <= {sel_sync_ff[0], EXT_ACCESS_SEL_B};
            din_meta_ff <= LOW_ADDR_DATA_PORT_IN;
            din_sync_ff <= din_meta_ff;
        end
    end

    // Reset pin must stay high for two whole machine cycles to count
    always @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rst_cnt_ff <= 5'h00;
            bus_rst_ff <= 1'b0;
        end
        else if (!rst_sync_ff[1])
        begin
            rst_cnt_ff <= 5'h00; // A short glitch restarts the count
            bus_rst_ff <= 1'b0;
        end
        else if (rst_cnt_ff != `RST_HOLD_CLKS)
        begin
            rst_cnt_ff <= rst_cnt_ff + 5'h01;
        end
        else
        begin
            bus_rst_ff <= 1'b1;
        end
    end

    assign take = REQ && !BUSY && !bus_rst_ff;

    // Internal only for code below the on-chip limit with select high
    assign go_internal = is_code(REQ_KIND) && sel_sync_ff[1]
                         && (REQ_ADDR < `ROM_LIMIT);

    // On-chip program store, read address straight from the request
    code_rom u_code_rom
    (
        .clk        (SYS_CLK),
        .prog_we    (ROM_PROG_WE),
        .prog_addr  (ROM_PROG_ADDR),
        .prog_data  (ROM_PROG_DATA),
        .rd_addr    (REQ_ADDR[`ROM_AW-1:0]),
        .rd_data_ff (rom_q)
    );

    // Bus sequencer: next values of every pin and answer
    always @*
    begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_kind     = kind_ff;
        nxt_wdata    = wdata_ff;
        nxt_busy     = BUSY;
        nxt_ack      = 1'b0;
        nxt_rdata    = RDATA;
        nxt_port_out = LOW_ADDR_DATA_PORT_OUT;
        nxt_port_oe  = LOW_ADDR_DATA_PORT_OE;
        nxt_high     = HIGH_ADDRESS_PORT;
        nxt_ale      = ADDR_LATCH_STB;
        nxt_fetch_b  = PROGRAM_FETCH_STB_B;
        nxt_wr_b     = DATA_WR_STB_B;
        nxt_rd_b     = DATA_RD_STB_B;
        case (state_ff)
            `ST_IDLE:
            begin
                nxt_busy = 1'b0;
                if (take && go_internal)
                begin
                    // Pins stay as they are, no strobe at all
                    nxt_state = `ST_ROM;
                    nxt_busy  = 1'b1;
                end
                else if (take)
                begin
                    nxt_state    = `ST_ADDR;
                    nxt_busy     = 1'b1;
                    nxt_kind     = REQ_KIND;
                    nxt_wdata    = REQ_WDATA;
                    nxt_cnt      = `ALE_CLKS;
                    nxt_high     = REQ_ADDR[15:8];
                    nxt_port_out = REQ_ADDR[7:0];
                    nxt_port_oe  = 8'hff;
                    nxt_ale      = 1'b1;
                end
            end
            `ST_ROM:
            begin
                nxt_ack   = 1'b1;
                nxt_rdata = rom_q;
                nxt_state = `ST_IDLE;
                nxt_busy  = 1'b0;
            end
            `ST_ADDR:
            begin
                nxt_cnt = cnt_ff - 3'h1;
                if (cnt_ff == 3'h1)
                begin
                    // Latch strobe falls while the address is still driven
                    nxt_ale   = 1'b0;
                    nxt_cnt   = `HOLD_CLKS;
                    nxt_state = `ST_HOLD;
                end
            end
            `ST_HOLD:
            begin
                nxt_cnt = cnt_ff - 3'h1;
                if (cnt_ff == 3'h1)
                begin
                    nxt_cnt   = `STB_CLKS;
                    nxt_state = `ST_STROBE;
                    if (kind_ff == `KIND_DATA_WR)
                    begin
                        nxt_port_out = wdata_ff;
                        nxt_wr_b     = 1'b0;
                    end
                    else
                    begin
                        nxt_port_oe = 8'h00; // Release port for the reader
                        if (is_code(kind_ff))
                        begin
                            nxt_fetch_b = 1'b0;
                        end
                        else
                        begin
                            nxt_rd_b = 1'b0;
                        end
                    end
                end
            end
            `ST_STROBE:
            begin
                nxt_cnt = cnt_ff - 3'h1;
                if (cnt_ff == 3'h1)
                begin
                    // Sample before the strobe rises; sync lag is two clocks
                    nxt_rdata   = din_sync_ff;
                    nxt_ack     = 1'b1;
                    nxt_fetch_b = 1'b1;
                    nxt_rd_b    = 1'b1;
                    nxt_wr_b    = 1'b1;
                    nxt_state   = `ST_END;
                end
            end
            `ST_END:
            begin
                // Write data held one clock past the strobe edge
                nxt_port_oe = 8'h00;
                nxt_state   = `ST_IDLE;
                nxt_busy    = 1'b0;
            end
            default:
            begin
                nxt_state = `ST_IDLE;
            end
        endcase
    end

    // State and pin registers; the held reset pin also returns to idle
    always @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_ff               <= `ST_IDLE;
            cnt_ff                 <= 3'h0;
            kind_ff                <= `KIND_FETCH;
            wdata_ff               <= 8'h00;
            BUSY                   <= 1'b1;
            ACK                    <= 1'b0;
            RDATA                  <= 8'h00;
            LOW_ADDR_DATA_PORT_OUT <= 8'h00;
            LOW_ADDR_DATA_PORT_OE  <= 8'h00;
            HIGH_ADDRESS_PORT      <= 8'h00;
            ADDR_LATCH_STB         <= 1'b0;
            PROGRAM_FETCH_STB_B    <= 1'b1;
            DATA_WR_STB_B          <= 1'b1;
            DATA_RD_STB_B          <= 1'b1;
        end
        else if (bus_rst_ff)
        begin
            state_ff               <= `ST_IDLE;
            cnt_ff                 <= 3'h0;
            kind_ff                <= `KIND_FETCH;
            wdata_ff               <= 8'h00;
            BUSY                   <= 1'b1;
            ACK                    <= 1'b0;
            RDATA                  <= 8'h00;
            LOW_ADDR_DATA_PORT_OUT <= 8'h00;
            LOW_ADDR_DATA_PORT_OE  <= 8'h00;
            HIGH_ADDRESS_PORT      <= 8'h00;
            ADDR_LATCH_STB         <= 1'b0;
            PROGRAM_FETCH_STB_B    <= 1'b1;
            DATA_WR_STB_B          <= 1'b1;
            DATA_RD_STB_B          <= 1'b1;
        end
        else
        begin
            state_ff               <= nxt_state;
            cnt_ff                 <= nxt_cnt;
            kind_ff                <= nxt_kind;
            wdata_ff               <= nxt_wdata;
            BUSY                   <= nxt_busy;
            ACK                    <= nxt_ack;
            RDATA                  <= nxt_rdata;
            LOW_ADDR_DATA_PORT_OUT <= nxt_port_out;
            LOW_ADDR_DATA_PORT_OE  <= nxt_port_oe;
            HIGH_ADDRESS_PORT      <= nxt_high;
            ADDR_LATCH_STB         <= nxt_ale;
            PROGRAM_FETCH_STB_B    <= nxt_fetch_b;
            DATA_WR_STB_B          <= nxt_wr_b;
            DATA_RD_STB_B          <= nxt_rd_b;
        end
    end

endmodule // ext_mem_bus

`default_nettype wire

// >>> ext_bus_defs.vh
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH

// Address spaces: program and data spaces are 64K each, 16-bit address
`define ADDR_W          16
`define ROM_AW          13
`define ROM_DEPTH       8192
// First program address that lies outside the on-chip ROM (8K bytes)
`define ROM_LIMIT       16'h2000

// Request kinds
`define KIND_FETCH      2'h0
`define KIND_CODE_LOAD  2'h1
`define KIND_DATA_RD    2'h2
`define KIND_DATA_WR    2'h3

// Machine cycle in oscillator clocks, and reset hold in machine cycles
`define MACH_CYC_CLKS   12
`define RST_HOLD_MC     2
// Reset pin hold in clocks: RST_HOLD_MC * MACH_CYC_CLKS = 24
`define RST_HOLD_CLKS   5'h18

// External bus phase lengths in clocks
`define ALE_CLKS        3'h2
`define HOLD_CLKS       3'h1
`define STB_CLKS        3'h4

// Bus state codes
`define ST_IDLE         3'h0
`define ST_ROM          3'h1
`define ST_ADDR         3'h2
`define ST_HOLD         3'h3
`define ST_STROBE       3'h4
`define ST_END          3'h5

`endif

// >>> code_rom.v
`timescale 1ns/1ps
`default_nettype none
`include "ext_bus_defs.vh"

module code_rom
(
    input  wire                 clk,
    input  wire                 prog_we,
    input  wire [`ROM_AW-1:0]   prog_addr,
    input  wire [7:0]           prog_data,
    input  wire [`ROM_AW-1:0]   rd_addr,
    output reg  [7:0]           rd_data_ff
);

    reg [7:0] mem [0:`ROM_DEPTH-1];

    // Programming write and registered read; no reset so it maps to block RAM
    always @(posedge clk)
    begin
        if (prog_we)
        begin
            mem[prog_addr] <= prog_data;
        end
        rd_data_ff <= mem[rd_addr];
    end

endmodule // code_rom

`default_nettype wire

// >>> ext_mem_bus_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_bus_sva
(
    input wire logic       SYS_CLK,
    input wire logic       RST_B,
    input wire logic       RESET_PIN,
    input wire logic       REQ,
    input wire logic       BUSY,
    input wire logic       ACK,
    input wire logic [7:0] LOW_ADDR_DATA_PORT_OUT,
    input wire logic [7:0] LOW_ADDR_DATA_PORT_OE,
    input wire logic [7:0] HIGH_ADDRESS_PORT,
    input wire logic       ADDR_LATCH_STB,
    input wire logic       PROGRAM_FETCH_STB_B,
    input wire logic       DATA_WR_STB_B,
    input wire logic       DATA_RD_STB_B
);
    logic [5:0] pin_cnt_ff;
    default clocking ck @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // Cycles the pin has been held; saturates so a long hold stays flagged
    always_ff @(posedge SYS_CLK or negedge RST_B)
        if (!RST_B) pin_cnt_ff <= 6'h00;
        else if (!RESET_PIN) pin_cnt_ff <= 6'h00;
        else if (pin_cnt_ff != 6'h3f) pin_cnt_ff <= pin_cnt_ff + 6'h01;

    a_ale_two_cycles: assert property (
        $rose(ADDR_LATCH_STB) |=> ADDR_LATCH_STB ##1 !ADDR_LATCH_STB) else $error("ale width");
    a_addr_held: assert property (
        $fell(ADDR_LATCH_STB) |-> LOW_ADDR_DATA_PORT_OE == 8'hff
        && $stable(LOW_ADDR_DATA_PORT_OUT) && $stable(HIGH_ADDRESS_PORT)) else $error("addr hold");
    a_data_after_addr: assert property (
        $fell(PROGRAM_FETCH_STB_B) |-> $past(ADDR_LATCH_STB, 2) && !$past(ADDR_LATCH_STB))
        else $error("fetch order");
    a_port_freed: assert property (
        !PROGRAM_FETCH_STB_B || !DATA_RD_STB_B |-> LOW_ADDR_DATA_PORT_OE == 8'h00)
        else $error("port not freed");
    a_write_drive: assert property (
        !DATA_WR_STB_B |-> LOW_ADDR_DATA_PORT_OE == 8'hff && DATA_RD_STB_B && PROGRAM_FETCH_STB_B)
        else $error("write strobe");
    a_read_width: assert property (
        $fell(DATA_RD_STB_B) |-> !DATA_RD_STB_B [*4] ##1 DATA_RD_STB_B) else $error("rd width");
    a_req_answered: assert property (
        REQ && !BUSY && !RESET_PIN |-> ##[1:8] ACK) else $error("no ack");
    a_pin_reset: assert property (
        pin_cnt_ff >= 6'h20 |-> BUSY && !ADDR_LATCH_STB && LOW_ADDR_DATA_PORT_OE == 8'h00
        && PROGRAM_FETCH_STB_B && DATA_RD_STB_B && DATA_WR_STB_B) else $error("pin reset");
    c_fetch: cover property ($fell(PROGRAM_FETCH_STB_B));
    c_write: cover property ($fell(DATA_WR_STB_B));
    c_read: cover property ($fell(DATA_RD_STB_B));
    c_pin: cover property (pin_cnt_ff == 6'h20);
endmodule // ext_mem_bus_sva

bind ext_mem_bus ext_mem_bus_sva i_sva (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
    .RESET_PIN(RESET_PIN), .REQ(REQ), .BUSY(BUSY), .ACK(ACK),
    .LOW_ADDR_DATA_PORT_OUT(LOW_ADDR_DATA_PORT_OUT), .LOW_ADDR_DATA_PORT_OE(LOW_ADDR_DATA_PORT_OE),
    .HIGH_ADDRESS_PORT(HIGH_ADDRESS_PORT), .ADDR_LATCH_STB(ADDR_LATCH_STB),
    .PROGRAM_FETCH_STB_B(PROGRAM_FETCH_STB_B), .DATA_WR_STB_B(DATA_WR_STB_B),
    .DATA_RD_STB_B(DATA_RD_STB_B));
`default_nettype wire

// >>> ext_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
(
    input  wire logic [7:0] port_out,
    input  wire logic [7:0] port_oe,
    input  wire logic [7:0] high,
    input  wire logic       ale,
    input  wire logic       fetch_b,
    input  wire logic       wr_b,
    input  wire logic       rd_b,
    output logic      [7:0] port_in
);
    logic [7:0] low_ff;
    logic [7:0] ram [0:65535];
    // Latch grabs the low byte as its strobe falls
    always @(negedge ale) low_ff = port_out;
    // Data memory takes the byte at the end of the write strobe
    always @(posedge wr_b) ram[{high, low_ff}] = port_out;
    // Memory drives only under its strobe; a floating port shows the inverse, not a stale match
    assign port_in = !fetch_b ? (high ^ {low_ff[6:0], low_ff[7]}) :
                     !rd_b ? ram[{high, low_ff}] : (port_oe == 8'hff ? port_out : ~port_out);
endmodule // ext_mem_model
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        clk = 1'h0, rst_b = 1'h0, rst_pin = 1'h0, sel_b = 1'h1;
    logic        req = 1'h0, pwe = 1'h0, seen = 1'h0;
    logic [1:0]  kind = 2'h0;
    logic [15:0] addr = 16'h0, a, ra [16];
    logic [12:0] paddr = 13'h0;
    logic [7:0]  wdata = 8'h0, pdata = 8'h0, wd [16];
    wire  [7:0]  p_out, p_oe, p_in, high, rdata;
    wire         busy, ack, ale, fet_b, wr_b, rd_b;
    int          num_errors = 0;
    int          compares = 0;

    always #20 clk = ~clk;

    ext_mem_bus i_dut (.SYS_CLK(clk), .RST_B(rst_b), .RESET_PIN(rst_pin),
        .EXT_ACCESS_SEL_B(sel_b), .REQ(req), .REQ_KIND(kind), .REQ_ADDR(addr),
        .REQ_WDATA(wdata), .BUSY(busy), .ACK(ack), .RDATA(rdata),
        .LOW_ADDR_DATA_PORT_IN(p_in), .LOW_ADDR_DATA_PORT_OUT(p_out),
        .LOW_ADDR_DATA_PORT_OE(p_oe), .HIGH_ADDRESS_PORT(high), .ADDR_LATCH_STB(ale),
        .PROGRAM_FETCH_STB_B(fet_b), .DATA_WR_STB_B(wr_b), .DATA_RD_STB_B(rd_b),
        .ROM_PROG_WE(pwe), .ROM_PROG_ADDR(paddr), .ROM_PROG_DATA(pdata));
    ext_mem_model i_mem (.port_out(p_out), .port_oe(p_oe), .high(high), .ale(ale),
        .fetch_b(fet_b), .wr_b(wr_b), .rd_b(rd_b), .port_in(p_in));

    // Code byte held by the external ROM at an address
    function automatic logic [7:0] code_of(input logic [15:0] x);
        return x[15:8] ^ {x[6:0], x[7]};
    endfunction

    task automatic complete_run();
        if (num_errors == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'h1)
        begin
            num_errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    // One access; internal ones must leave every bus pin quiet
    task automatic acc(input logic [1:0] k, input logic [15:0] x, input logic [7:0] d,
                       input logic ext, input logic [7:0] exp);
        int n;
        n = 0;
        while (busy !== 1'h0 && n < 40)
        begin
            @(posedge clk);
            #1 n++;
        end
        req = 1'h1;
        kind = k;
        addr = x;
        wdata = d;
        @(posedge clk);
        #1 req = 1'h0;
        seen = 1'h0;
        n = 0;
        while (ack !== 1'h1 && n < 20)
        begin
            @(posedge clk);
            #1 n++;
        end
        chk((ext ? n == 7 : n == 1) && seen === ext && (k == 2'h3 || rdata === exp),
            "access");
    endtask

    // Any pin activity since the take edge
    always @(posedge clk)
        if (ale === 1'h1 || p_oe !== 8'h00 || fet_b !== 1'h1 || rd_b !== 1'h1 || wr_b !== 1'h1)
            seen <= 1'h1;

    // Hang guard, far beyond the under one thousand cycles the tests need
    initial
    begin
        #400000;
        num_errors++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h14a9988e));
        repeat (10) @(posedge clk);
        #1 rst_b = 1'h1;
        for (int i = 0; i < 16; i++)
        begin
            ra[i] = (i == 0) ? 16'h0 : (i == 1) ? 16'h1fff : {3'h0, 13'($urandom)};
            @(posedge clk);
            #1 pwe = 1'h1;
            paddr = ra[i][12:0];
            pdata = ~code_of(ra[i]);
        end
        @(posedge clk);
        #1 pwe = 1'h0;
        foreach (ra[i]) acc(2'(i % 2), ra[i], 8'h0, 1'h0, ~code_of(ra[i]));
        for (int i = 0; i < 12; i++)
        begin
            a = (i == 0) ? 16'h2000 : (i == 1) ? 16'hffff : 16'h2000 + 16'($urandom % 16'he000);
            acc(2'(i % 2), a, 8'h0, 1'h1, code_of(a));
        end
        sel_b = 1'h0;
        repeat (4) @(posedge clk);
        #1;
        foreach (ra[i]) acc(2'(i % 2), ra[i], 8'h0, 1'h1, code_of(ra[i]));
        sel_b = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        // Writes back to back, then reads in reverse order
        for (int i = 0; i < 16; i++)
        begin
            ra[i] = {4'(i), 12'($urandom)};
            wd[i] = 8'($urandom);
            acc(2'h3, ra[i], wd[i], 1'h1, 8'h0);
        end
        for (int i = 15; i >= 0; i--) acc(2'h2, ra[i], 8'h0, 1'h1, wd[i]);
        acc(2'h0, ra[2], 8'h0, 1'h1, code_of(ra[2]));
        // A short pin pulse must not reset; a long one must
        rst_pin = 1'h1;
        repeat (10) @(posedge clk);
        #1 rst_pin = 1'h0;
        repeat (4) @(posedge clk);
        #1 chk(high === ra[2][15:8] && busy === 1'h0, "glitch reset");
        rst_pin = 1'h1;
        acc(2'h1, 16'hc000, 8'h0, 1'h1, code_of(16'hc000));
        repeat (30) @(posedge clk);
        #1 chk(busy === 1'h1 && high === 8'h0 && p_oe === 8'h0 && ale === 1'h0 && rdata === 8'h0
               && ack === 1'h0 && p_out === 8'h0, "pin");
        rst_pin = 1'h0;
        acc(2'h0, 16'he001, 8'h0, 1'h1, code_of(16'he001));
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
